// File: design/cms_pkg.sv
// Constants, types and register map of the charge mode select block
//------------------------------------------------------------
//------------------------------------------------------------
package cms_pkg;
	// Clock rate and times
	localparam int CLK_KHZ = 50000;
	localparam int PW_IDLE_MS = 15000;
	localparam int LOAD_ON_MS = 200;
	localparam int LOAD_OFF_MS = 3000;
	localparam int REATTACH_MS = 2000;
	localparam int MODE_DISCH_MS = 100;
	localparam int CNT_W = 30;

	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATE = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

	// Field positions
	localparam int CTRL_OVR_BIT = 0;
	localparam int CTRL_PIN_LSB = 1;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_LIM_LSB = 4;
	localparam int ST_STATUS_BIT = 8;
	localparam int ST_DISCH_BIT = 9;
	localparam int ST_DATA_BIT = 10;
	localparam int ST_PW_LSB = 12;
	localparam int IRQ_LOAD_ON = 0;
	localparam int IRQ_LOAD_OFF = 1;
	localparam int IRQ_MODE = 2;
	localparam int IRQ_W = 3;

	// Charging modes, Gray coded along the usual path
	typedef enum logic [2:0] {
		MD_DISCH = 3'h0,
		MD_AUTO = 3'h1,
		MD_PLAIN = 3'h3,
		MD_ALT = 3'h2,
		MD_CDP = 3'h6,
		MD_SHORT = 3'h7,
		MD_DIV1 = 3'h5
	} cms_mode_e;

	// Current limit source
	typedef enum logic [1:0] {
		LIM_NONE = 2'h0,
		LIM_LOWER = 2'h1,
		LIM_UPPER = 2'h3,
		LIM_STANDBY = 2'h2
	} cms_lim_e;

	// Load detect flavour
	typedef enum logic [1:0] {
		LD_OFF = 2'h0,
		LD_PW = 2'h1,
		LD_NPW = 2'h3
	} cms_ld_e;

	// Power wake states
	typedef enum logic [1:0] {
		PW_CHG = 2'h0,
		PW_STBY = 2'h1,
		PW_REDIS = 2'h3
	} cms_pw_e;

	typedef struct packed {
		logic mode_sel_a;
		logic mode_sel_b;
		logic mode_sel_c;
		logic limit_choice;
	} cms_pins_s;

	typedef struct packed {
		logic load_hi;
		logic load_lo;
		logic pw_low;
		logic stby_over;
		logic pri_det;
		logic hid_det;
	} cms_ana_s;

	typedef struct packed {
		cms_mode_e mode;
		cms_lim_e lim;
		cms_ld_e ld;
	} cms_cfg_s;
endpackage

// File: design/cms_sync.sv
// Three stage input synchroniser with agreement filter
`timescale 1ns/1ns
module cms_sync #(
	parameter int W = 10
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	genvar i;
	//------------------------------------------------------------
	// Per bit chain
	//------------------------------------------------------------
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			// First stage read only by the second
			always_ff @(posedge CLK_SYS) begin
				if (RST) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					Q[i] <= 1'b0;
				end else begin
					s1_r <= D[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						Q[i] <= s3_r; // Change counts once two stages agree
					end
				end
			end
		end
	endgenerate
endmodule

// File: design/cms_top.sv
// Charge mode decode, load detect and register slave
`timescale 1ns/1ns
module cms_top #(
	parameter logic [cms_pkg::CNT_W-1:0] T_ON_CYC =
		cms_pkg::CNT_W'(cms_pkg::LOAD_ON_MS * cms_pkg::CLK_KHZ),
	parameter logic [cms_pkg::CNT_W-1:0] T_OFF_CYC =
		cms_pkg::CNT_W'(cms_pkg::LOAD_OFF_MS * cms_pkg::CLK_KHZ),
	parameter logic [cms_pkg::CNT_W-1:0] T_IDLE_CYC =
		cms_pkg::CNT_W'(cms_pkg::PW_IDLE_MS * cms_pkg::CLK_KHZ),
	parameter logic [cms_pkg::CNT_W-1:0] T_REAT_CYC =
		cms_pkg::CNT_W'(cms_pkg::REATTACH_MS * cms_pkg::CLK_KHZ),
	parameter logic [cms_pkg::CNT_W-1:0] T_MDIS_CYC =
		cms_pkg::CNT_W'(cms_pkg::MODE_DISCH_MS * cms_pkg::CLK_KHZ)
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic MODE_SEL_A,
	input wire logic MODE_SEL_B,
	input wire logic MODE_SEL_C,
	input wire logic LIMIT_CHOICE,
	input wire logic LOAD_HI,
	input wire logic LOAD_LO,
	input wire logic PW_LOW,
	input wire logic STBY_OVER,
	input wire logic PRI_DET,
	input wire logic HID_DET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic STATUS_N,
	output logic DATA_SW_EN,
	output logic PWR_SW_EN,
	output logic DISCH_EN,
	output logic [1:0] ILIM_SRC,
	output logic [2:0] CHG_MODE,
	output logic IRQ
);
	localparam logic [cms_pkg::CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [cms_pkg::CNT_W-1:0] CNT_ONE = cms_pkg::CNT_W'(1);

	cms_pkg::cms_pins_s pins_raw;
	cms_pkg::cms_pins_s pins_sync;
	cms_pkg::cms_pins_s pins_eff;
	cms_pkg::cms_ana_s ana_raw;
	cms_pkg::cms_ana_s ana;
	cms_pkg::cms_cfg_s want;
	cms_pkg::cms_cfg_s cur_r;
	cms_pkg::cms_pw_e pw_r;
	logic [2:0] cur_sel_r;
	logic [4:0] ctrl_r;
	logic [cms_pkg::IRQ_W-1:0] irq_stat_r;
	logic [cms_pkg::IRQ_W-1:0] irq_mask_r;
	logic [cms_pkg::IRQ_W-1:0] irq_set;
	logic [cms_pkg::CNT_W-1:0] dis_cnt_r;
	logic [cms_pkg::CNT_W-1:0] on_cnt_r;
	logic [cms_pkg::CNT_W-1:0] off_cnt_r;
	logic [cms_pkg::CNT_W-1:0] idle_cnt_r;
	logic load_r;
	logic load_prev_r;
	logic pri_prev_r;
	logic hid_seen_r;
	logic hold_req;
	logic change;
	logic mode_evt;
	logic discharging;
	logic go_redis;
	logic wr_en;
	logic rd_setup;
	logic hit;
	logic [31:0] rd_nxt;
	cms_pkg::cms_lim_e lim_nxt;

	//------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------
	// Pins and comparator flags come from outside this clock
	assign pins_raw = {MODE_SEL_A, MODE_SEL_B, MODE_SEL_C, LIMIT_CHOICE};
	assign ana_raw = {LOAD_HI, LOAD_LO, PW_LOW, STBY_OVER, PRI_DET, HID_DET};

	cms_sync #(
		.W(10)
	) u_sync (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.D({pins_raw, ana_raw}),
		.Q({pins_sync, ana})
	);

	// Software may take over the select pins for bring-up
	assign pins_eff = ctrl_r[cms_pkg::CTRL_OVR_BIT] ?
		cms_pkg::cms_pins_s'(ctrl_r[cms_pkg::CTRL_PIN_LSB +: 4]) : pins_sync;

	//------------------------------------------------------------
	// Mode decode
	//------------------------------------------------------------
	// Full case over all eight select patterns
	always_comb begin
		want = '{cms_pkg::MD_DISCH, cms_pkg::LIM_NONE, cms_pkg::LD_OFF};
		lim_nxt = pins_eff.limit_choice ? cms_pkg::LIM_UPPER : cms_pkg::LIM_LOWER;
		case ({pins_eff.mode_sel_a, pins_eff.mode_sel_b, pins_eff.mode_sel_c})
			3'h0: begin
				want = '{cms_pkg::MD_DISCH, cms_pkg::LIM_NONE, cms_pkg::LD_OFF};
			end
			3'h1: begin
				want.mode = cms_pkg::MD_AUTO;
				want.lim = cms_pkg::LIM_UPPER;
				want.ld = pins_eff.limit_choice ? cms_pkg::LD_PW : cms_pkg::LD_OFF;
			end
			3'h3: begin
				want.mode = cms_pkg::MD_AUTO;
				want.lim = cms_pkg::LIM_UPPER;
				want.ld = pins_eff.limit_choice ? cms_pkg::LD_NPW : cms_pkg::LD_OFF;
			end
			3'h2, 3'h6: begin
				want = '{cms_pkg::MD_PLAIN, lim_nxt, cms_pkg::LD_OFF};
			end
			3'h4: begin
				want = '{cms_pkg::MD_SHORT, lim_nxt, cms_pkg::LD_OFF};
			end
			3'h5: begin
				want = '{cms_pkg::MD_DIV1, lim_nxt, cms_pkg::LD_OFF};
			end
			3'h7: begin
				if (pins_eff.limit_choice) begin
					want = '{cms_pkg::MD_CDP, cms_pkg::LIM_UPPER, cms_pkg::LD_NPW};
				end else begin
					want = '{cms_pkg::MD_ALT, cms_pkg::LIM_LOWER, cms_pkg::LD_OFF};
				end
			end
			default: begin
				want = '{cms_pkg::MD_DISCH, cms_pkg::LIM_NONE, cms_pkg::LD_OFF};
			end
		endcase
	end

	// Keep data path when a keyboard or mouse was seen and auto is asked
	// Only 111->011 and 010->011 qualify; 110 may pass through 111
	assign hold_req = hid_seen_r &&
		({pins_eff.mode_sel_a, pins_eff.mode_sel_b, pins_eff.mode_sel_c} == 3'h3) &&
		((cur_sel_r == 3'h7) || (cur_sel_r == 3'h2));

	// Alt data and charging downstream swap without discharge
	assign change = !hold_req && (want.mode != cur_r.mode) &&
		!(((want.mode == cms_pkg::MD_ALT) && (cur_r.mode == cms_pkg::MD_CDP)) ||
		((want.mode == cms_pkg::MD_CDP) && (cur_r.mode == cms_pkg::MD_ALT)));

	//------------------------------------------------------------
	// Current mode register
	//------------------------------------------------------------
	// Mode follows pins at once unless hold_req; no power state involved
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cur_r <= '{cms_pkg::MD_DISCH, cms_pkg::LIM_NONE, cms_pkg::LD_OFF};
			cur_sel_r <= 3'h0;
			mode_evt <= 1'b0;
		end else begin
			mode_evt <= !hold_req && (want.mode != cur_r.mode);
			if (!hold_req) begin
				cur_r <= want;
				cur_sel_r <= {pins_eff.mode_sel_a, pins_eff.mode_sel_b, pins_eff.mode_sel_c};
			end
		end
	end

	// Remember an attached keyboard or mouse while data lines are live
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			hid_seen_r <= 1'b0;
		end else if ((cur_r.mode == cms_pkg::MD_PLAIN) || (cur_r.mode == cms_pkg::MD_CDP) ||
			(cur_r.mode == cms_pkg::MD_ALT)) begin
			hid_seen_r <= ana.hid_det;
		end else if (!hold_req) begin
			hid_seen_r <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Output discharge timer
	//------------------------------------------------------------
	// Mode change renegotiates; re-attach holds discharge for T_REAT_CYC
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dis_cnt_r <= CNT_ZERO;
		end else if (change) begin
			dis_cnt_r <= T_MDIS_CYC;
		end else if (go_redis) begin
			dis_cnt_r <= T_REAT_CYC;
		end else if (dis_cnt_r != CNT_ZERO) begin
			dis_cnt_r <= dis_cnt_r - CNT_ONE;
		end
	end

	assign discharging = (dis_cnt_r != CNT_ZERO) || (cur_r.mode == cms_pkg::MD_DISCH);

	//------------------------------------------------------------
	// Power wake state machine
	//------------------------------------------------------------
	assign go_redis = (pw_r == cms_pkg::PW_STBY) && ana.stby_over && (cur_r.ld == cms_pkg::LD_PW);

	// Idle detect, standby limit and re-attach
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pw_r <= cms_pkg::PW_CHG;
			idle_cnt_r <= CNT_ZERO;
		end else if (cur_r.ld != cms_pkg::LD_PW) begin
			pw_r <= cms_pkg::PW_CHG;
			idle_cnt_r <= CNT_ZERO;
		end else begin
			case (pw_r)
				cms_pkg::PW_CHG: begin
					if (!ana.pw_low) begin
						idle_cnt_r <= CNT_ZERO;
					end else if (idle_cnt_r >= T_IDLE_CYC) begin
						pw_r <= cms_pkg::PW_STBY;
						idle_cnt_r <= CNT_ZERO;
					end else begin
						idle_cnt_r <= idle_cnt_r + CNT_ONE;
					end
				end
				cms_pkg::PW_STBY: begin
					if (go_redis) begin
						pw_r <= cms_pkg::PW_REDIS;
					end
				end
				cms_pkg::PW_REDIS: begin
					if (dis_cnt_r == CNT_ZERO) begin
						pw_r <= cms_pkg::PW_CHG;
					end
				end
				default: begin
					pw_r <= cms_pkg::PW_CHG;
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// Load present detection
	//------------------------------------------------------------
	// Filters on lower limit plus 60mA and plus 10mA comparators
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			on_cnt_r <= CNT_ZERO;
			off_cnt_r <= CNT_ZERO;
		end else begin
			on_cnt_r <= (ana.load_hi && !load_r) ? on_cnt_r + CNT_ONE : CNT_ZERO;
			off_cnt_r <= (ana.load_lo && load_r) ? off_cnt_r + CNT_ONE : CNT_ZERO;
		end
	end

	// Status level per load detect flavour
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			load_r <= 1'b0;
			pri_prev_r <= 1'b0;
		end else begin
			pri_prev_r <= ana.pri_det;
			case (cur_r.ld)
				cms_pkg::LD_PW: begin
					load_r <= (pw_r != cms_pkg::PW_STBY) && !go_redis;
				end
				cms_pkg::LD_NPW: begin
					if ((cur_r.mode == cms_pkg::MD_CDP) && ana.pri_det && !pri_prev_r) begin
						load_r <= 1'b1;
					end else if (on_cnt_r >= T_ON_CYC) begin
						load_r <= 1'b1;
					end else if (off_cnt_r >= T_OFF_CYC) begin
						load_r <= 1'b0;
					end
				end
				default: begin
					load_r <= 1'b0;
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// Port outputs
	//------------------------------------------------------------
	// All registered so pins never glitch on decode changes
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			STATUS_N <= 1'b1;
			DATA_SW_EN <= 1'b0;
			PWR_SW_EN <= 1'b0;
			DISCH_EN <= 1'b1;
			ILIM_SRC <= cms_pkg::LIM_NONE;
			CHG_MODE <= cms_pkg::MD_DISCH;
		end else begin
			STATUS_N <= !load_r;
			DATA_SW_EN <= !discharging && ((cur_r.mode == cms_pkg::MD_PLAIN) ||
				(cur_r.mode == cms_pkg::MD_ALT) || (cur_r.mode == cms_pkg::MD_CDP));
			PWR_SW_EN <= !discharging;
			DISCH_EN <= discharging;
			CHG_MODE <= cur_r.mode;
			if (discharging) begin
				ILIM_SRC <= cms_pkg::LIM_NONE;
			end else if ((cur_r.ld == cms_pkg::LD_PW) && (pw_r == cms_pkg::PW_STBY)) begin
				ILIM_SRC <= cms_pkg::LIM_STANDBY;
			end else begin
				ILIM_SRC <= cur_r.lim;
			end
		end
	end

	//------------------------------------------------------------
	// Interrupts
	//------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			load_prev_r <= 1'b0;
		end else begin
			load_prev_r <= load_r;
		end
	end

	assign irq_set[cms_pkg::IRQ_LOAD_ON] = load_r && !load_prev_r;
	assign irq_set[cms_pkg::IRQ_LOAD_OFF] = !load_r && load_prev_r;
	assign irq_set[cms_pkg::IRQ_MODE] = mode_evt;

	// Write one clears; a new event in the same cycle wins
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			irq_stat_r <= '0;
		end else if (wr_en && (PADDR == cms_pkg::REG_IRQ_STAT)) begin
			irq_stat_r <= (irq_stat_r & ~PWDATA[cms_pkg::IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	assign IRQ = |(irq_stat_r & irq_mask_r);

	//------------------------------------------------------------
	// APB slave
	//------------------------------------------------------------
	// Zero wait states: data is fetched in the setup cycle
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign hit = (PADDR == cms_pkg::REG_CTRL) || (PADDR == cms_pkg::REG_STATE) ||
		(PADDR == cms_pkg::REG_IRQ_STAT) || (PADDR == cms_pkg::REG_IRQ_MASK);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit;

	// Writable registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ctrl_r <= '0;
			irq_mask_r <= '0;
		end else if (wr_en) begin
			if (PADDR == cms_pkg::REG_CTRL) begin
				ctrl_r <= PWDATA[4:0];
			end
			if (PADDR == cms_pkg::REG_IRQ_MASK) begin
				irq_mask_r <= PWDATA[cms_pkg::IRQ_W-1:0];
			end
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		rd_nxt = 32'h0;
		case (PADDR)
			cms_pkg::REG_CTRL: begin
				rd_nxt[4:0] = ctrl_r;
			end
			cms_pkg::REG_STATE: begin
				rd_nxt[cms_pkg::ST_MODE_LSB +: 3] = cur_r.mode;
				rd_nxt[cms_pkg::ST_LIM_LSB +: 2] = ILIM_SRC;
				rd_nxt[cms_pkg::ST_STATUS_BIT] = load_r;
				rd_nxt[cms_pkg::ST_DISCH_BIT] = discharging;
				rd_nxt[cms_pkg::ST_DATA_BIT] = DATA_SW_EN;
				rd_nxt[cms_pkg::ST_PW_LSB +: 2] = pw_r;
			end
			cms_pkg::REG_IRQ_STAT: begin
				rd_nxt[cms_pkg::IRQ_W-1:0] = irq_stat_r;
			end
			cms_pkg::REG_IRQ_MASK: begin
				rd_nxt[cms_pkg::IRQ_W-1:0] = irq_mask_r;
			end
			default: begin
				rd_nxt = 32'h0;
			end
		endcase
	end

	// Read data register
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PRDATA <= 32'h0;
		end else if (rd_setup) begin
			PRDATA <= rd_nxt;
		end
	end
endmodule

// File: verif/cms_properties.sv
// Concurrent checks on the ports of the charge mode select top
`timescale 1ns/1ns
module cms_properties #(
	parameter logic [cms_pkg::CNT_W-1:0] T_ON_CYC = 30'd10
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic MODE_SEL_A,
	input wire logic MODE_SEL_B,
	input wire logic MODE_SEL_C,
	input wire logic LIMIT_CHOICE,
	input wire logic LOAD_HI,
	input wire logic STBY_OVER,
	input wire logic PRI_DET,
	input wire logic STATUS_N,
	input wire logic DATA_SW_EN,
	input wire logic PWR_SW_EN,
	input wire logic DISCH_EN,
	input wire logic [1:0] ILIM_SRC,
	input wire logic [2:0] CHG_MODE
);
	logic [cms_pkg::CNT_W-1:0] hi_cnt;
	logic hi_ok;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// Held load in the non power wake auto mode, pins already settled
	assign hi_ok = LOAD_HI && !DISCH_EN && CHG_MODE == 3'h1
		&& {MODE_SEL_A, MODE_SEL_B, MODE_SEL_C, LIMIT_CHOICE} == 4'h7;
	// Run length of that load; short runs never reach the compare
	always_ff @(posedge CLK_SYS) begin
		if (RST || !hi_ok) begin
			hi_cnt <= '0;
		end else begin
			hi_cnt <= hi_cnt + 1'b1;
		end
	end
	//------------------------------------------------------------
	// Mode outputs
	//------------------------------------------------------------
	sequence s_swap;
		(CHG_MODE == 3'h2 ##1 CHG_MODE == 3'h6) or (CHG_MODE == 3'h6 ##1 CHG_MODE == 3'h2);
	endsequence
	sequence s_quiet;
		(CHG_MODE inside {3'h0, 3'h2, 3'h3, 3'h5, 3'h7})[*4];
	endsequence
	a_disch_hold: assert property ($stable(CHG_MODE) && CHG_MODE == 3'h0
		|-> DISCH_EN && !PWR_SW_EN && !DATA_SW_EN && ILIM_SRC == 2'h0)
		else $error("discharge mode not holding output low");
	a_lines_off: assert property ($stable(CHG_MODE)
		&& CHG_MODE inside {3'h1, 3'h5, 3'h7} |-> !DATA_SW_EN)
		else $error("data lines on in a dedicated mode");
	a_cdp_upper: assert property ($stable(CHG_MODE) && CHG_MODE == 3'h6 && !DISCH_EN
		|-> ILIM_SRC == 2'h3 && DATA_SW_EN)
		else $error("charging downstream mode limit or lines wrong");
	a_alt_lower: assert property ($stable(CHG_MODE) && CHG_MODE == 3'h2 && !DISCH_EN
		|-> ILIM_SRC == 2'h1 && DATA_SW_EN)
		else $error("alternate data mode limit or lines wrong");
	a_swap_nodis: assert property (s_swap |-> !DISCH_EN[*3])
		else $error("discharge on alternate data swap");
	a_status_quiet: assert property (s_quiet |-> STATUS_N)
		else $error("status active in a mode without detection");
	//------------------------------------------------------------
	// Load detection
	//------------------------------------------------------------
	a_load_early: assert property ($rose(LOAD_HI) && STATUS_N && CHG_MODE == 3'h1
		|-> STATUS_N[*8])
		else $error("status asserted before the load qualify time");
	a_load_on: assert property (hi_cnt == T_ON_CYC + 30'd8 |-> !STATUS_N)
		else $error("held load not reported");
	a_pri_det: assert property ($rose(PRI_DET) && CHG_MODE == 3'h6 && !DISCH_EN
		|-> ##[1:10] !STATUS_N)
		else $error("primary detection not reported");
	a_reattach: assert property ($rose(STBY_OVER) && ILIM_SRC == 2'h2
		|-> ##[1:10] (DISCH_EN && !PWR_SW_EN && !STATUS_N))
		else $error("standby overload did not discharge");
endmodule

// File: verif/cms_sysctl_model.sv
// System controller model: drives the mode pins and watches load status
`timescale 1ns/1ns
module cms_sysctl_model (
	input wire logic clk,
	input wire cms_pkg::cms_pins_s cmd,
	input wire logic status_n,
	output cms_pkg::cms_pins_s pins,
	output int load_seen
);
	logic status_q;
	// Pins move just after an edge, as a GPIO port would
	initial pins = '0;
	always @(posedge clk) begin
		pins <= cmd;
	end
	// Count load reports; low on the line means load present
	initial load_seen = 0;
	initial status_q = 1'b1;
	always @(posedge clk) begin
		status_q <= status_n;
		if (status_q === 1'b1 && status_n === 1'b0) load_seen <= load_seen + 1;
	end
endmodule

// File: verif/charge_mode_select_tb_top.sv
// Self-checking bench for the charge mode select block
`timescale 1ns/1ns
module charge_mode_select_tb_top;
	localparam logic [29:0] T_ON = 30'd10;
	localparam logic [29:0] T_OFF = 30'd20;
	localparam logic [29:0] T_IDLE = 30'd30;
	localparam logic [29:0] T_REAT = 30'd15;
	// Per pin code: mode, limit source, data switch, status
	localparam logic [6:0] TT [16] = '{7'h01, 7'h01, 7'h1D, 7'h1C, 7'h37, 7'h3F, 7'h1D,
		7'h1D, 7'h75, 7'h7D, 7'h55, 7'h5D, 7'h37, 7'h3F, 7'h27, 7'h6F};
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	cms_pkg::cms_pins_s cmd = '0;
	cms_pkg::cms_pins_s pins;
	cms_pkg::cms_ana_s ana = '0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA, rd;
	logic PREADY, PSLVERR, STATUS_N, DATA_SW_EN, PWR_SW_EN, DISCH_EN, IRQ, err;
	logic [1:0] ILIM_SRC;
	logic [2:0] CHG_MODE;
	int num_errors = 0;
	int cmp_count = 0;
	int load_seen;
	// Free running 50 MHz clock
	always #10 CLK_SYS = ~CLK_SYS;
	cms_sysctl_model ctl (.clk(CLK_SYS), .cmd(cmd), .status_n(STATUS_N), .pins(pins),
		.load_seen(load_seen));
	cms_top #(.T_ON_CYC(T_ON), .T_OFF_CYC(T_OFF), .T_IDLE_CYC(T_IDLE), .T_REAT_CYC(T_REAT),
		.T_MDIS_CYC(30'd5)) uut (.CLK_SYS(CLK_SYS), .RST(RST),
		.MODE_SEL_A(pins.mode_sel_a), .MODE_SEL_B(pins.mode_sel_b),
		.MODE_SEL_C(pins.mode_sel_c), .LIMIT_CHOICE(pins.limit_choice),
		.LOAD_HI(ana.load_hi), .LOAD_LO(ana.load_lo), .PW_LOW(ana.pw_low),
		.STBY_OVER(ana.stby_over), .PRI_DET(ana.pri_det), .HID_DET(ana.hid_det),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STATUS_N(STATUS_N),
		.DATA_SW_EN(DATA_SW_EN), .PWR_SW_EN(PWR_SW_EN), .DISCH_EN(DISCH_EN),
		.ILIM_SRC(ILIM_SRC), .CHG_MODE(CHG_MODE), .IRQ(IRQ));
	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic summarize();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic set_pins(input logic [3:0] p);
		@(posedge CLK_SYS);
		cmd <= p;
	endtask
	task automatic set_ana(input logic [5:0] a);
		@(posedge CLK_SYS);
		ana <= a;
	endtask
	// Wait for a mode to settle; counts discharge cycles seen meanwhile
	task automatic settle(input logic [2:0] m, output int dis);
		int n;
		dis = 0;
		for (n = 0; n < 80; n++) begin
			@(negedge CLK_SYS);
			if (DISCH_EN === 1'b1) dis++;
			if (n > 8 && CHG_MODE === m && (m == 3'h0 || DISCH_EN === 1'b0)) break;
		end
		if (n == 80) begin
			chk("settle timeout", 0, 1);
			summarize();
		end
	endtask
	// Wait for status (0), limit source (1) or discharge (2) to reach v
	task automatic wait_on(input int sel, input logic [1:0] v, output int c);
		logic [1:0] s;
		for (c = 0; c < 200; c++) begin
			@(negedge CLK_SYS);
			s = sel == 0 ? {1'b0, STATUS_N} : sel == 1 ? ILIM_SRC : {1'b0, DISCH_EN};
			if (s === v) break;
		end
		if (c == 200) begin
			chk("wait timeout", sel, 4);
			summarize();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge CLK_SYS);
			if (PREADY === 1'b1) break;
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n == 20) begin
			chk("ready timeout", 0, 1);
			summarize();
		end
	endtask
	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_table();
		int dis;
		for (int i = 0; i < 16; i++) begin
			set_pins(i[3:0]);
			settle(TT[i][6:4], dis);
			repeat (3) @(negedge CLK_SYS);
			chk("decode", TT[i], {CHG_MODE, ILIM_SRC, DATA_SW_EN, STATUS_N});
			if (i == 15) chk("swap discharge", 0, dis);
		end
	endtask
	task automatic t_load();
		int c;
		set_pins(4'h7);
		settle(3'h1, c);
		set_ana(6'h20);
		wait_on(0, 2'h0, c);
		chk("assert time", 1, c >= T_ON);
		// Keep the load on so the checker's run counter reaches its compare
		repeat (4) @(negedge CLK_SYS);
		set_ana(6'h10);
		wait_on(0, 2'h1, c);
		chk("release time", 1, c >= T_OFF);
		chk("partner saw load", 1, load_seen > 0);
		set_pins(4'h6);
		settle(3'h1, c);
		set_ana(6'h20);
		repeat (40) @(negedge CLK_SYS);
		chk("no detect on choice 0", 1, STATUS_N);
		set_ana(6'h00);
	endtask
	task automatic t_cdp_pw();
		int c;
		set_pins(4'hF);
		settle(3'h6, c);
		set_ana(6'h02);
		wait_on(0, 2'h0, c);
		chk("primary detect fast", 1, c < T_ON);
		set_ana(6'h10);
		wait_on(0, 2'h1, c);
		set_ana(6'h00);
		set_pins(4'h3);
		settle(3'h1, c);
		chk("wake status", 0, STATUS_N);
		set_ana(6'h08);
		wait_on(1, 2'h2, c);
		chk("idle time", 1, c >= T_IDLE);
		repeat (3) @(negedge CLK_SYS);
		chk("idle status", 1, STATUS_N);
		set_ana(6'h04);
		wait_on(0, 2'h0, c);
		set_ana(6'h00);
		wait_on(2, 2'h0, c);
		chk("reattach discharge", 1, c >= T_REAT - 4);
		repeat (2) @(negedge CLK_SYS);
		chk("upper restored", 3, ILIM_SRC);
	endtask
	task automatic t_hid_regs();
		int c;
		set_pins(4'hF);
		settle(3'h6, c);
		set_ana(6'h01);
		set_pins(4'h7);
		repeat (30) @(negedge CLK_SYS);
		chk("wake hold", 6, CHG_MODE);
		set_ana(6'h00);
		apb(1'b0, cms_pkg::REG_IRQ_MASK, 32'h0);
		chk("mask reset", 0, rd);
		chk("irq masked", 0, IRQ);
		apb(1'b1, cms_pkg::REG_IRQ_MASK, 32'h4);
		@(negedge CLK_SYS);
		chk("irq raised", 1, IRQ);
		apb(1'b1, cms_pkg::REG_IRQ_STAT, 32'h7);
		@(negedge CLK_SYS);
		chk("irq cleared", 0, IRQ);
		apb(1'b1, cms_pkg::REG_CTRL, 32'h13);
		settle(3'h7, c);
		chk("mode event irq", 1, IRQ);
		apb(1'b0, cms_pkg::REG_CTRL, 32'h0);
		chk("ctrl readback", 32'h13, rd);
		chk("mapped no error", 0, err);
		apb(1'b0, cms_pkg::REG_STATE, 32'h0);
		chk("state", 11'h037, rd[10:0]);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		apb(1'b1, cms_pkg::REG_CTRL, 32'h0);
	endtask
	// Main sequence
	initial begin
		repeat (7) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		chk("reset outputs", 10'h300, {STATUS_N, DISCH_EN, PWR_SW_EN, DATA_SW_EN, ILIM_SRC,
			CHG_MODE, IRQ});
		@(posedge CLK_SYS);
		RST <= 1'b0;
		t_table();
		t_load();
		t_cdp_pw();
		t_hid_regs();
		summarize();
	end
endmodule

bind cms_top cms_properties #(.T_ON_CYC(T_ON_CYC)) u_props (.CLK_SYS(CLK_SYS), .RST(RST),
	.MODE_SEL_A(MODE_SEL_A), .MODE_SEL_B(MODE_SEL_B), .MODE_SEL_C(MODE_SEL_C),
	.LIMIT_CHOICE(LIMIT_CHOICE), .LOAD_HI(LOAD_HI), .STBY_OVER(STBY_OVER),
	.PRI_DET(PRI_DET), .STATUS_N(STATUS_N), .DATA_SW_EN(DATA_SW_EN), .PWR_SW_EN(PWR_SW_EN),
	.DISCH_EN(DISCH_EN), .ILIM_SRC(ILIM_SRC), .CHG_MODE(CHG_MODE));
